//--- inc/msd_pkg.sv
// Package of constants and carrier types for the memory space decoder
package msd_pkg;

  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam logic [15:0] VECTOR_BASE     = 16'h0003;
  localparam int          VECTOR_STRIDE   = 8;
  localparam logic [7:0]  BANK_TOP        = 8'h1f;
  localparam logic [7:0]  BITAREA_BASE    = 8'h20;
  localparam logic [7:0]  BITAREA_TOP     = 8'h2f;
  localparam logic [7:0]  UPPER_BASE      = 8'h80;
  localparam int          REGS_PER_BANK   = 8;
  localparam int          CLKS_PER_MCYCLE = 4;
  localparam logic [1:0]  BANK_RESET      = 2'h0;

  typedef enum logic [1:0] {
    MSD_RAM, MSD_SFR, MSD_EXT_CODE, MSD_EXT_DATA
  } msd_target_e;

  // Kind of operand address the core presents
  typedef enum logic [2:0] {
    MSD_ACC_DIRECT, MSD_ACC_INDIRECT, MSD_ACC_STACK, MSD_ACC_REG,
    MSD_ACC_BIT, MSD_ACC_EXTERNAL_DATA_SPACE, MSD_ACC_CODE
  } msd_kind_e;

  // Placement of companion memories; bit0 program space, bit1 data space
  typedef struct packed {
    logic [1:0] main_flash;
    logic [1:0] second_flash;
    logic       sram_in_code;
  } msd_place_s;

  typedef struct packed {
    msd_kind_e  kind;
    logic       write;
    logic [15:0] addr;
  } msd_req_s;

  typedef struct packed {
    msd_target_e target;
    logic [7:0]  int_addr;
    logic [2:0]  bit_pos;
    logic        bit_mode;
    logic        sel_main;
    logic        sel_second;
    logic        sel_sram;
    logic        sel_ctrl;
    logic        refused;
  } msd_dec_s;

  function automatic logic [15:0] vector_of(input logic [2:0] src);
    vector_of = VECTOR_BASE + 16'(int'(src) * VECTOR_STRIDE);
  endfunction : vector_of

endpackage : msd_pkg

//--- verilog/msd_cycle_timer.sv
// Machine-cycle phase counter of four core clocks
module msd_cycle_timer
  import msd_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  // Phase
  output logic [1:0]      phase_o,
  output logic            mcycle_end_o
);

  logic [1:0] phase_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= (phase_q == 2'(CLKS_PER_MCYCLE - 1)) ? 2'h0 : phase_q + 2'h1;
    end
  end

  assign phase_o      = phase_q;
  assign mcycle_end_o = (phase_q == 2'(CLKS_PER_MCYCLE - 1));

  a_cycle_len: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    mcycle_end_o |=> !mcycle_end_o [*3] ##1 mcycle_end_o)
    else $error("machine cycle is not four clocks");

endmodule : msd_cycle_timer

//--- verilog/msd_addr_decode.sv
// Combinational address-space decoder
module msd_addr_decode
  import msd_pkg::*;
(
  // Request
  input  msd_req_s        req_i,
  input  wire logic [1:0] bank_i,
  input  msd_place_s      place_i,
  // Result
  output msd_dec_s        dec_o
);

  function automatic logic in_space(input logic [1:0] pl, input logic code);
    in_space = code ? pl[0] : pl[1];
  endfunction : in_space

  always_comb begin
    logic [7:0] a;
    a = req_i.addr[7:0];
    dec_o = '0;
    dec_o.int_addr = a;
    dec_o.target = MSD_RAM;
    case (req_i.kind)
      MSD_ACC_REG: begin
        dec_o.int_addr = {3'h0, bank_i, a[2:0]};
      end
      MSD_ACC_DIRECT: begin
        if (a >= UPPER_BASE) dec_o.target = MSD_SFR;
      end
      MSD_ACC_INDIRECT, MSD_ACC_STACK: begin
        dec_o.target = MSD_RAM;
      end
      MSD_ACC_BIT: begin
        dec_o.bit_mode = 1'b1;
        dec_o.bit_pos  = a[2:0];
        if (a[7]) begin
          dec_o.target   = MSD_SFR;
          dec_o.int_addr = {a[7:3], 3'h0};
        end else begin
          dec_o.int_addr = 8'(BITAREA_BASE + {4'h0, a[6:3]});
        end
      end
      MSD_ACC_EXTERNAL_DATA_SPACE: begin
        dec_o.target     = MSD_EXT_DATA;
        dec_o.sel_main   = in_space(place_i.main_flash, 1'b0);
        dec_o.sel_second = in_space(place_i.second_flash, 1'b0);
        dec_o.sel_sram   = 1'b1;
        dec_o.sel_ctrl   = 1'b1;
      end
      MSD_ACC_CODE: begin
        dec_o.target     = MSD_EXT_CODE;
        dec_o.sel_main   = in_space(place_i.main_flash, 1'b1);
        dec_o.sel_second = in_space(place_i.second_flash, 1'b1);
        dec_o.sel_sram   = place_i.sram_in_code;
        dec_o.refused    = req_i.write;
      end
      default: dec_o.refused = 1'b1;
    endcase
  end

endmodule : msd_addr_decode

//--- verilog/msd_space_ctrl.sv
// Top of the memory space decoder: registered access steering and vectors
module msd_space_ctrl
  import msd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // Core request
  input  wire logic        req_valid_i,
  input  msd_req_s         req_i,
  input  wire logic [1:0]  psw_bank_i,
  input  wire logic        psw_bank_we_i,
  // Program flow
  input  wire logic        branch_i,
  input  wire logic [15:0] branch_addr_i,
  input  wire logic        pc_step_i,
  input  wire logic        irq_take_i,
  input  wire logic [2:0]  irq_src_i,
  // Placement
  input  msd_place_s       place_nv_i,
  input  wire logic        update_ovr_i,
  input  msd_place_s       place_ovr_i,
  // Results
  output msd_dec_s         dec_o,
  output logic [15:0]      ext_addr_o,
  output logic [7:0]       int_addr_o,
  output logic             program_fetch_strobe_n_o,
  output logic             data_read_strobe_n_o,
  output logic             data_write_strobe_n_o,
  output logic [15:0]      program_counter_o,
  output logic [1:0]       bank_o,
  output logic [1:0]       phase_o
);

  logic [1:0]  phase;
  logic        mcycle_end;
  logic [1:0]  bank_q;
  logic [15:0] pc_q;
  msd_place_s  place_q;
  msd_place_s  nv_s1_q, nv_s2_q;
  logic        ovr_s1_q, ovr_s2_q;
  logic        rst_done_q;
  msd_dec_s    dec_c;
  msd_dec_s    dec_q;
  logic [15:0] ext_q;
  logic        program_fetch_strobe_n_n_q, rd_n_q, wr_n_q;
  logic        take_code_c, take_data_c;

  // ********************
  // Machine cycle
  // ********************
  msd_cycle_timer u_timer (
    .clk_sys_i    (clk_sys_i),
    .rstn_i       (rstn_i),
    .phase_o      (phase),
    .mcycle_end_o (mcycle_end)
  );

  // ********************
  // Bank select
  // ********************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bank_q <= BANK_RESET;
    end else if (psw_bank_we_i) begin
      bank_q <= psw_bank_i;
    end
  end

  // ********************
  // Program counter and vectors
  // ********************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_q <= RESET_VECTOR;
    end else if (irq_take_i) begin
      pc_q <= vector_of(irq_src_i);
    end else if (branch_i) begin
      pc_q <= branch_addr_i;
    end else if (pc_step_i) begin
      pc_q <= pc_q + 16'h1;
    end
  end

  // ********************
  // Placement, loaded after reset release
  // ********************
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nv_s1_q  <= '0;
      nv_s2_q  <= '0;
      ovr_s1_q <= 1'b0;
      ovr_s2_q <= 1'b0;
    end else begin
      nv_s1_q  <= place_nv_i;
      nv_s2_q  <= nv_s1_q;
      ovr_s1_q <= update_ovr_i;
      ovr_s2_q <= ovr_s1_q;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_done_q <= 1'b0;
      place_q    <= '0;
    end else begin
      rst_done_q <= 1'b1;
      if (!rst_done_q || !ovr_s2_q) begin
        place_q <= nv_s2_q;
      end else begin
        place_q <= place_ovr_i;
      end
    end
  end

  // ********************
  // Decode and strobes
  // ********************
  msd_addr_decode u_dec (
    .req_i   (req_i),
    .bank_i  (bank_q),
    .place_i (place_q),
    .dec_o   (dec_c)
  );

  // Request accepted this cycle for program or data space
  assign take_code_c = req_valid_i && !dec_c.refused && dec_c.target == MSD_EXT_CODE;
  assign take_data_c = req_valid_i && !dec_c.refused && dec_c.target == MSD_EXT_DATA;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dec_q <= '0;
      ext_q <= 16'h0000;
    end else if (req_valid_i) begin
      dec_q <= dec_c;
      ext_q <= req_i.addr;
    end
  end

  // Strobes stand for one cycle per accepted request
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      program_fetch_strobe_n_n_q <= 1'b1;
    end else begin
      program_fetch_strobe_n_n_q <= !take_code_c;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      rd_n_q <= !(take_data_c && !req_i.write);
      wr_n_q <= !(take_data_c && req_i.write);
    end
  end

  assign dec_o                    = dec_q;
  assign ext_addr_o               = ext_q;
  assign int_addr_o               = dec_q.int_addr;
  assign program_fetch_strobe_n_o = program_fetch_strobe_n_n_q;
  assign data_read_strobe_n_o     = rd_n_q;
  assign data_write_strobe_n_o    = wr_n_q;
  assign program_counter_o        = pc_q;
  assign bank_o                   = bank_q;
  assign phase_o                  = phase;

  // ********************
  // Checks: internal space
  // ********************
  a_reg_in_bank: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_REG |=> int_addr_o[7:3] == {3'h0, $past(bank_q)}
      && int_addr_o <= BANK_TOP)
    else $error("register operand left the active bank");

  a_bit_area: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_BIT && !req_i.addr[7] |=>
      int_addr_o >= BITAREA_BASE && int_addr_o <= BITAREA_TOP)
    else $error("bit address outside bit area");

  a_bit_pos: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_BIT |=>
      dec_o.bit_mode && dec_o.bit_pos == $past(req_i.addr[2:0]))
    else $error("bit position not carried");

  a_upper_ind: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind inside {MSD_ACC_INDIRECT, MSD_ACC_STACK} |=>
      dec_o.target == MSD_RAM && int_addr_o == $past(req_i.addr[7:0]))
    else $error("indirect access did not reach RAM");

  a_lower_both: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind inside {MSD_ACC_DIRECT, MSD_ACC_INDIRECT} && !req_i.addr[7] |=>
      dec_o.target == MSD_RAM && int_addr_o == $past(req_i.addr[7:0]))
    else $error("lower RAM not reached");

  a_direct_sfr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_DIRECT |=>
      (dec_o.target == MSD_SFR) == $past(req_i.addr[7]))
    else $error("direct access routed wrongly");

  a_sfr_bit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_BIT && req_i.addr[7] |=>
      int_addr_o[2:0] == 3'h0 && dec_o.target == MSD_SFR)
    else $error("bit access to non-bit special register");

  a_no_ext_int: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    dec_o.target == MSD_RAM || dec_o.target == MSD_SFR |->
      data_read_strobe_n_o && data_write_strobe_n_o)
    else $error("external strobe on internal access");

  // ********************
  // Checks: external space
  // ********************
  a_ext_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i |=> ext_addr_o == $past(req_i.addr))
    else $error("external address not carried");

  a_fetch_strobe: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_CODE && !req_i.write |=>
      !program_fetch_strobe_n_o ##1 program_fetch_strobe_n_o || $past(req_valid_i))
    else $error("code fetch not strobed");

  a_fetch_code_only: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !program_fetch_strobe_n_o |-> dec_o.target == MSD_EXT_CODE && !dec_o.refused)
    else $error("fetch strobe without code read");

  a_no_code_wr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_CODE && req_i.write |=>
      program_fetch_strobe_n_o && data_write_strobe_n_o)
    else $error("program space was written");

  a_data_place: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_EXTERNAL_DATA_SPACE |=>
      dec_o.sel_sram && dec_o.sel_ctrl && !data_read_strobe_n_o == !$past(req_i.write))
    else $error("data space access mis-steered");

  a_one_data_strobe: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !data_read_strobe_n_o || !data_write_strobe_n_o |->
      data_read_strobe_n_o != data_write_strobe_n_o && dec_o.target == MSD_EXT_DATA)
    else $error("data strobes not exclusive");

  a_strobe_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !req_valid_i |=>
      program_fetch_strobe_n_o && data_read_strobe_n_o && data_write_strobe_n_o)
    else $error("strobe without request");

  // ********************
  // Checks: placement
  // ********************
  a_code_place: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_CODE |=> !dec_o.sel_ctrl
      && dec_o.sel_sram == $past(place_q.sram_in_code))
    else $error("program space selects wrong memory");

  a_flash_data: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_EXTERNAL_DATA_SPACE |=>
      dec_o.sel_main == $past(place_q.main_flash[1])
      && dec_o.sel_second == $past(place_q.second_flash[1]))
    else $error("flash not steered into data space");

  a_flash_code: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    req_valid_i && req_i.kind == MSD_ACC_CODE |=>
      dec_o.sel_main == $past(place_q.main_flash[0])
      && dec_o.sel_second == $past(place_q.second_flash[0]))
    else $error("flash not steered into program space");

  a_place_stored: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !ovr_s2_q |=> place_q == $past(nv_s2_q))
    else $error("stored placement not applied");

  a_place_update: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rst_done_q && ovr_s2_q |=> place_q == $past(place_ovr_i))
    else $error("update placement not applied");

  // ********************
  // Checks: program flow and bank
  // ********************
  a_reset_pc: assert property (@(posedge clk_sys_i)
    $rose(rstn_i) |-> program_counter_o == RESET_VECTOR)
    else $error("program counter not at reset vector");

  a_reset_bank: assert property (@(posedge clk_sys_i)
    $rose(rstn_i) |-> bank_o == BANK_RESET)
    else $error("bank not cleared by reset");

  a_reset_strobes: assert property (@(posedge clk_sys_i)
    $rose(rstn_i) |->
      program_fetch_strobe_n_o && data_read_strobe_n_o && data_write_strobe_n_o)
    else $error("strobe active out of reset");

  a_irq_vector: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    irq_take_i |=> program_counter_o == 16'h0003 + {10'h0, $past(irq_src_i), 3'h0})
    else $error("wrong interrupt vector");

  a_pc_branch: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    branch_i && !irq_take_i |=> program_counter_o == $past(branch_addr_i))
    else $error("branch target not loaded");

  a_pc_step: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pc_step_i && !branch_i && !irq_take_i |=>
      program_counter_o == $past(program_counter_o) + 16'h1)
    else $error("program counter did not step");

  a_pc_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !pc_step_i && !branch_i && !irq_take_i |=>
      $stable(program_counter_o))
    else $error("program counter moved on its own");

  a_bank_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    psw_bank_we_i |=> bank_o == $past(psw_bank_i))
    else $error("bank select not loaded");

  a_bank_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !psw_bank_we_i |=> $stable(bank_o))
    else $error("active bank changed without a load");

endmodule : msd_space_ctrl

//--- verif/msd_mem_model.sv
// Companion memory model that counts the external strobes it receives
module msd_mem_model
  import msd_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  // Strobes and decode from the core side
  input  wire logic fetch_n_i,
  input  wire logic rd_n_i,
  input  wire logic wr_n_i,
  input  msd_dec_s  dec_i,
  // Access counts
  output int        n_fetch_o,
  output int        n_read_o,
  output int        n_write_o,
  output int        n_code_wr_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Strobes last one cycle, so each low sample is one access
  always @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      n_fetch_o   <= 0;
      n_read_o    <= 0;
      n_write_o   <= 0;
      n_code_wr_o <= 0;
    end else begin
      if (!fetch_n_i)
        n_fetch_o <= n_fetch_o + 1;
      if (!rd_n_i)
        n_read_o <= n_read_o + 1;
      if (!wr_n_i)
        n_write_o <= n_write_o + 1;
      if (!wr_n_i && dec_i.target == MSD_EXT_CODE)
        n_code_wr_o <= n_code_wr_o + 1;
    end
  end
endmodule : msd_mem_model

//--- verif/msd_space_ctrl_tb.sv
// Self-checking bench for the memory space decoder
module msd_space_ctrl_tb import msd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Signals
  // ********************
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        vld   = 1'b0;
  logic        bwe   = 1'b0;
  logic        br    = 1'b0;
  logic        stp   = 1'b0;
  logic        irq   = 1'b0;
  logic        ovr   = 1'b0;
  logic [1:0]  bank  = 2'h0;
  logic [2:0]  src   = 3'h0;
  logic [15:0] baddr = 16'h0000;
  msd_req_s    req   = '0;
  msd_place_s  pnv   = '0;
  msd_place_s  pov   = '0;
  msd_dec_s    dec;
  logic [15:0] ea, pc;
  logic [7:0]  ia;
  logic        fs_n, rd_n, wr_n;
  logic [1:0]  bko, ph;
  int          nf, nr, nw, ncw;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  typedef struct {msd_kind_e k; logic [7:0] a; msd_target_e t; logic [7:0] ia; logic [2:0] bp;}
    msd_row_s;
  // Internal-space decode cases: kind, address, expected target, internal address, bit position
  msd_row_s rows [10] = '{
    '{MSD_ACC_DIRECT,   8'h7f, MSD_RAM, 8'h7f, 3'h0}, '{MSD_ACC_INDIRECT, 8'h10, MSD_RAM, 8'h10, 3'h0},
    '{MSD_ACC_INDIRECT, 8'h80, MSD_RAM, 8'h80, 3'h0}, '{MSD_ACC_STACK,    8'hff, MSD_RAM, 8'hff, 3'h0},
    '{MSD_ACC_STACK,    8'h05, MSD_RAM, 8'h05, 3'h0}, '{MSD_ACC_DIRECT,   8'h80, MSD_SFR, 8'h80, 3'h0},
    '{MSD_ACC_DIRECT,   8'hd0, MSD_SFR, 8'hd0, 3'h0}, '{MSD_ACC_BIT,      8'h00, MSD_RAM, 8'h20, 3'h0},
    '{MSD_ACC_BIT,      8'h7f, MSD_RAM, 8'h2f, 3'h7}, '{MSD_ACC_BIT,      8'hd3, MSD_SFR, 8'hd0, 3'h3}
  };

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      test_done();
    end
  end

  msd_space_ctrl dut (
    .clk_sys_i(clk), .rstn_i(rst_n), .req_valid_i(vld), .req_i(req), .psw_bank_i(bank),
    .psw_bank_we_i(bwe), .branch_i(br), .branch_addr_i(baddr), .pc_step_i(stp),
    .irq_take_i(irq), .irq_src_i(src), .place_nv_i(pnv), .update_ovr_i(ovr),
    .place_ovr_i(pov), .dec_o(dec), .ext_addr_o(ea), .int_addr_o(ia),
    .program_fetch_strobe_n_o(fs_n), .data_read_strobe_n_o(rd_n),
    .data_write_strobe_n_o(wr_n), .program_counter_o(pc), .bank_o(bko), .phase_o(ph)
  );

  msd_mem_model mem (
    .clk_sys_i(clk), .rstn_i(rst_n), .fetch_n_i(fs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .dec_i(dec), .n_fetch_o(nf), .n_read_o(nr), .n_write_o(nw), .n_code_wr_o(ncw)
  );
  // ********************
  // Tasks
  // ********************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("Checks %0d, errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic access(input msd_kind_e k, input logic w, input logic [15:0] a);
    @(negedge clk);
    req.kind = k;
    req.write = w;
    req.addr = a;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask : access

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk("pc", 32'(pc), 32'h0);
    chk("bank", 32'(bko), 32'h0);
    chk("strobes", 32'({fs_n, rd_n, wr_n}), 32'h7);
    chk("phase", 32'(ph), 32'h0);
  endtask : do_reset

  task automatic t_external();
    access(MSD_ACC_EXTERNAL_DATA_SPACE, 1'b0, 16'hffff);
    chk("rd_n", 32'({rd_n, wr_n}), 32'h1);
    chk("ext_addr", 32'(ea), 32'hffff);
    chk("target", 32'(dec.target), 32'(MSD_EXT_DATA));
    access(MSD_ACC_EXTERNAL_DATA_SPACE, 1'b1, 16'h0000);
    chk("wr_n", 32'({rd_n, wr_n}), 32'h2);
    access(MSD_ACC_CODE, 1'b0, 16'hfffe);
    chk("fetch_n", 32'(fs_n), 32'h0);
    chk("ext_addr", 32'(ea), 32'hfffe);
    access(MSD_ACC_CODE, 1'b1, 16'h1234);
    chk("refused", 32'({dec.refused, fs_n, wr_n}), 32'h7);
    access(msd_kind_e'(3'h7), 1'b0, 16'h0042);
    chk("bad kind", 32'({dec.refused, fs_n, rd_n, wr_n}), 32'hf);
    @(negedge clk);
    chk("writes", 32'(ncw + nw), 32'h1);
    chk("reads", 32'(nr), 32'h1);
    chk("fetches", 32'(nf), 32'h1);
  endtask : t_external

  task automatic t_internal();
    int n0;
    n0 = nf + nr + nw;
    foreach (rows[i]) begin
      access(rows[i].k, 1'b0, {8'h00, rows[i].a});
      chk("target", 32'(dec.target), 32'(rows[i].t));
      chk("int_addr", 32'(ia), 32'(rows[i].ia));
      chk("bit_mode", 32'(dec.bit_mode), 32'(rows[i].k == MSD_ACC_BIT));
      if (rows[i].k == MSD_ACC_BIT)
        chk("bit_pos", 32'(dec.bit_pos), 32'(rows[i].bp));
    end
    chk("ext strobes", 32'(nf + nr + nw), 32'(n0));
  endtask : t_internal

  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      @(negedge clk);
      bank = 2'(b);
      bwe = 1'b1;
      @(negedge clk);
      bwe = 1'b0;
      chk("bank", 32'(bko), 32'(b));
      access(MSD_ACC_REG, 1'b0, 16'h00fd);
      chk("reg addr", 32'(ia), 32'({b[1:0], 3'h5}));
    end
  endtask : t_banks

  task automatic t_flow();
    for (int s = 0; s < 8; s++) begin
      @(negedge clk);
      src = 3'(s);
      irq = 1'b1;
      br = (s == 1);
      @(negedge clk);
      irq = 1'b0;
      br = 1'b0;
      chk("vector", 32'(pc), 32'(16'h0003 + 16'(8 * s)));
    end
    @(negedge clk);
    baddr = 16'hfffe;
    br = 1'b1;
    @(negedge clk);
    br = 1'b0;
    stp = 1'b1;
    chk("branch", 32'(pc), 32'hfffe);
    @(negedge clk);
    stp = 1'b0;
    chk("step", 32'(pc), 32'hffff);
  endtask : t_flow

  task automatic t_phase();
    logic [1:0] p;
    p = ph;
    @(negedge clk);
    chk("phase", 32'(ph), 32'(2'(p + 2'h1)));
    repeat (3) @(negedge clk);
    chk("phase", 32'(ph), 32'(p));
  endtask : t_phase

  task automatic t_place(input logic [1:0] m, input logic [1:0] s, input logic c);
    access(MSD_ACC_EXTERNAL_DATA_SPACE, 1'b0, 16'h8000);
    chk("data sel", 32'({dec.sel_main, dec.sel_second}), 32'({m[1], s[1]}));
    chk("data ram", 32'({dec.sel_sram, dec.sel_ctrl}), 32'h3);
    access(MSD_ACC_CODE, 1'b0, 16'h8000);
    chk("code sel", 32'({dec.sel_main, dec.sel_second}), 32'({m[0], s[0]}));
    chk("code ram", 32'({dec.sel_sram, dec.sel_ctrl}), 32'({c, 1'b0}));
  endtask : t_place
  // ********************
  // Main sequence
  // ********************
  initial begin
    do_reset();
    t_external();
    t_internal();
    t_banks();
    t_flow();
    t_phase();
    pnv = '{main_flash: 2'h1, second_flash: 2'h2, sram_in_code: 1'b1};
    repeat (4) @(negedge clk);
    t_place(2'h1, 2'h2, 1'b1);
    pov = '{main_flash: 2'h2, second_flash: 2'h3, sram_in_code: 1'b0};
    ovr = 1'b1;
    repeat (4) @(negedge clk);
    t_place(2'h2, 2'h3, 1'b0);
    ovr = 1'b0;
    do_reset();
    repeat (4) @(negedge clk);
    t_place(2'h1, 2'h2, 1'b1);
    test_done();
  end
endmodule : msd_space_ctrl_tb
